// File: hdl/rx_overrun_pkg.sv
// Shared types and constants for the receive overrun statistics block
package rx_overrun_pkg;

   // Counter geometry and values after reset
   localparam int          COUNT_WIDTH  = 32;
   localparam logic [31:0] COUNT_RESET  = 32'h0000_0000;
   localparam logic [31:0] COUNT_STEP   = 32'h0000_0001;
   localparam int          BUFFER_DEPTH = 2;

   // One receive byte from the MAC receive path
   typedef struct packed {
      logic [7:0] data;
      logic       first;
      logic       last;
   } rx_beat_s;

   // Frame classification, valid on the beat that carries last
   typedef struct packed {
      logic data_or_ctrl;
      logic addr_match;
      logic promisc_hit;
      logic crc_error;
      logic align_error;
      logic code_error;
   } rx_qual_s;

   localparam int BEAT_WIDTH = $bits(rx_beat_s);

   // Frame tracker states, Gray coded along idle, receive, drop
   typedef enum logic [1:0] {
      FRAME_IDLE = 2'h0,
      FRAME_RECV = 2'h1,
      FRAME_DROP = 2'h3
   } frame_state_e;

endpackage

// File: hdl/cell_buffer.sv
// Small valid/ready cell FIFO between the MAC receive path and the DMA
`timescale 1ns/100ps
module cell_buffer
#(
   parameter int WIDTH = 10,
   parameter int DEPTH = 2
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_b,
   // Filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [WIDTH-1:0] cells_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   // Wrap a pointer at the depth, which need not be a power of two
   function automatic logic [PW-1:0] advance(input logic [PW-1:0] ptr);
      if (ptr == PW'(DEPTH - 1))
      begin
         return '0;
      end
      return ptr + PW'(1);
   endfunction

   // Full and empty come straight from the occupancy count
   assign in_ready  = (count_reg != FULL_COUNT);
   assign out_valid = (count_reg != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = cells_reg[rd_ptr_reg];

   // Storage needs no reset; only occupied cells are ever read
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         cells_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= advance(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= advance(rd_ptr_reg);
         end
         if (push && !pop)
         begin
            count_reg <= count_reg + CW'(1);
         end
         else if (pop && !push)
         begin
            count_reg <= count_reg - CW'(1);
         end
      end
   end

endmodule // cell_buffer

// File: hdl/rx_overrun_statistics.sv
// Receive path cell buffer with start, middle and descriptor overrun counters
//
// Summary of operation
// (RQ1) A qualifying frame that finds the cell buffer full or no DMA buffer on its first beat counts one start overrun.
// (RQ2) A qualifying frame that started cleanly but later lost a beat to either shortage counts one middle overrun.
// (RQ3) A qualifying frame whose first lost beat, at start or midway, met a zero head descriptor counts one descriptor overrun.
// (RQ4) Frame length plays no part, so runts and oversized frames count like any other.
// (RQ5) Only data or control frames that passed address filtering or promiscuous acceptance qualify.
// (RQ6) CRC, alignment and code errors neither cause nor prevent any overrun count.
// (RQ7) Each counter moves at most once per frame however many shortages the frame meets.
`timescale 1ns/100ps
module rx_overrun_statistics
#(
   parameter int CW = rx_overrun_pkg::COUNT_WIDTH
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // MAC receive beats, cannot be stalled
   input  wire logic                     rx_valid,
   input  wire rx_overrun_pkg::rx_beat_s rx_beat,
   input  wire rx_overrun_pkg::rx_qual_s rx_qual,
   // DMA side
   input  wire logic                     desc_head_zero,
   output logic                          dma_valid,
   input  wire logic                     dma_ready,
   output rx_overrun_pkg::rx_beat_s      dma_beat,
   // Statistics
   output logic [CW-1:0]                 rx_start_overrun_count,
   output logic [CW-1:0]                 rx_middle_overrun_count,
   output logic [CW-1:0]                 rx_descriptor_overrun_count
);

   localparam logic [CW-1:0] CNT_RESET = CW'(rx_overrun_pkg::COUNT_RESET);
   localparam logic [CW-1:0] CNT_STEP  = CW'(rx_overrun_pkg::COUNT_STEP);

   rx_overrun_pkg::frame_state_e state_reg;
   rx_overrun_pkg::frame_state_e state_next;
   logic sof_ovr_reg;
   logic mid_ovr_reg;
   logic dma_ovr_reg;
   logic buf_in_ready;
   logic buf_in_valid;
   logic shortage;
   logic is_start;
   logic in_body;
   logic sof_hit;
   logic mid_hit;
   logic dma_hit;
   logic sof_any;
   logic mid_any;
   logic dma_any;
   logic frame_end;
   logic qualified;
   logic [rx_overrun_pkg::BEAT_WIDTH-1:0] dma_bits;

   // Wrapping counter step, shared by all three statistics
   function automatic logic [CW-1:0] bump(input logic [CW-1:0] cnt, input logic hit);
      return hit ? cnt + CNT_STEP : cnt;
   endfunction

   // Resource check for the beat now on the receive path
   assign shortage  = !buf_in_ready || desc_head_zero;
   // A first beat always opens a new frame; an unterminated one is abandoned
   assign is_start  = rx_valid && rx_beat.first;
   assign in_body   = rx_valid && !rx_beat.first && (state_reg == rx_overrun_pkg::FRAME_RECV);
   assign sof_hit   = is_start && shortage;                            // see RQ1
   assign mid_hit   = in_body && shortage;                             // see RQ2
   assign dma_hit   = (sof_hit || mid_hit) && desc_head_zero;          // see RQ3

   // Flags seen so far in this frame, with a new start wiping the old ones
   assign sof_any   = sof_hit || (!is_start && sof_ovr_reg);
   assign mid_any   = mid_hit || (!is_start && mid_ovr_reg);
   assign dma_any   = dma_hit || (!is_start && dma_ovr_reg);

   // Frame closes on last; length is never examined, so runts count too
   assign frame_end = rx_valid && rx_beat.last && (is_start || state_reg != rx_overrun_pkg::FRAME_IDLE); // see RQ4
   // Error flags deliberately take no part in qualification
   assign qualified = rx_qual.data_or_ctrl && (rx_qual.addr_match || rx_qual.promisc_hit); // see RQ5, RQ6

   // Only beats of a frame not yet overrun enter the cell buffer
   assign buf_in_valid = (is_start || in_body) && !shortage;

   // Next frame tracker state
   always_comb
   begin
      state_next = state_reg;
      if (is_start)
      begin
         if (rx_beat.last)
         begin
            state_next = rx_overrun_pkg::FRAME_IDLE;
         end
         else if (shortage)
         begin
            state_next = rx_overrun_pkg::FRAME_DROP;
         end
         else
         begin
            state_next = rx_overrun_pkg::FRAME_RECV;
         end
      end
      else if (rx_valid)
      begin
         case (state_reg)
            rx_overrun_pkg::FRAME_RECV:
            begin
               if (rx_beat.last)
               begin
                  state_next = rx_overrun_pkg::FRAME_IDLE;
               end
               else if (shortage)
               begin
                  // Rest of frame is discarded, no second middle hit
                  state_next = rx_overrun_pkg::FRAME_DROP;   // see RQ7
               end
            end
            rx_overrun_pkg::FRAME_DROP:
            begin
               if (rx_beat.last)
               begin
                  state_next = rx_overrun_pkg::FRAME_IDLE;
               end
            end
            default:
            begin
               state_next = rx_overrun_pkg::FRAME_IDLE;
            end
         endcase
      end
   end

   // Frame tracker state
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= rx_overrun_pkg::FRAME_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Per-frame overrun flags, sticky until the frame closes or the next frame opens
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sof_ovr_reg <= 1'b0;
         mid_ovr_reg <= 1'b0;
         dma_ovr_reg <= 1'b0;
      end
      else
      begin
         sof_ovr_reg <= sof_any && !frame_end;
         mid_ovr_reg <= mid_any && !frame_end;
         dma_ovr_reg <= dma_any && !frame_end;
      end
   end

   // Counters step once at frame close, so repeated shortages cannot add more
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_start_overrun_count      <= CNT_RESET;
         rx_middle_overrun_count     <= CNT_RESET;
         rx_descriptor_overrun_count <= CNT_RESET;
      end
      else if (frame_end && qualified)                                 // see RQ7
      begin
         rx_start_overrun_count      <= bump(rx_start_overrun_count, sof_any);      // see RQ1
         rx_middle_overrun_count     <= bump(rx_middle_overrun_count, mid_any);     // see RQ2
         rx_descriptor_overrun_count <= bump(rx_descriptor_overrun_count, dma_any); // see RQ3
      end
   end

   // Cell buffer; a stalled DMA fills it and further beats become overruns
   cell_buffer
   #(
      .WIDTH (rx_overrun_pkg::BEAT_WIDTH),
      .DEPTH (rx_overrun_pkg::BUFFER_DEPTH)
   )
   u_cells
   (
      .clk       (clk),
      .rst_b     (rst_b),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (rx_beat),
      .out_valid (dma_valid),
      .out_ready (dma_ready),
      .out_data  (dma_bits)
   );

   assign dma_beat = rx_overrun_pkg::rx_beat_s'(dma_bits);

   // Checks on the counters and frame tracking
   sequence s_qual_close;
      frame_end && qualified;
   endsequence

   sequence s_runt_start_overrun;
      is_start && rx_beat.last && shortage;
   endsequence

   sof_count_step_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ1
      s_qual_close ##0 sof_any |=> rx_start_overrun_count == $past(rx_start_overrun_count) + CNT_STEP)
      else $error("start overrun count did not step at qualifying frame close");

   mid_after_sof_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ2
      s_qual_close ##0 (sof_any && !mid_hit) |=> $stable(rx_middle_overrun_count))
      else $error("middle overrun counted for a frame with a start overrun");

   fifo_only_loss_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ3
      (frame_end && !dma_any) |=> $stable(rx_descriptor_overrun_count))
      else $error("descriptor overrun counted without a zero head pointer");

   runt_counted_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ4
      s_runt_start_overrun ##0 qualified |=> rx_start_overrun_count != $past(rx_start_overrun_count))
      else $error("single beat frame with start overrun was not counted");

   unqualified_hold_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ5
      (frame_end && !qualified) |=> $stable(rx_start_overrun_count) && $stable(rx_middle_overrun_count))
      else $error("unqualified frame changed an overrun counter");

   errors_ignored_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ6
      s_qual_close ##0 (dma_any && (rx_qual.crc_error || rx_qual.align_error || rx_qual.code_error))
      |=> rx_descriptor_overrun_count == $past(rx_descriptor_overrun_count) + CNT_STEP)
      else $error("errored frame with descriptor overrun was not counted");

   once_per_frame_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ7
      !frame_end |=> $stable(rx_start_overrun_count) && $stable(rx_middle_overrun_count)
      && $stable(rx_descriptor_overrun_count))
      else $error("overrun counter moved outside a frame close");

   drop_no_push_a : assert property (@(posedge clk) disable iff (!rst_b) // see RQ2
      (state_reg == rx_overrun_pkg::FRAME_DROP && !is_start) |-> !buf_in_valid)
      else $error("beat of an overrun frame entered the cell buffer");

endmodule // rx_overrun_statistics

// File: verification/dma_sink_model.sv
// DMA sink model: takes beats from the cell buffer, stalls on request
`timescale 1ns/100ps
module dma_sink_model
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_b,
   // Control from the bench
   input  wire logic                     stall,
   input  wire logic                     desc_zero,
   // Buffer side
   input  wire logic                     dma_valid,
   output logic                          dma_ready,
   input  wire rx_overrun_pkg::rx_beat_s dma_beat,
   output logic                          desc_head_zero,
   // Accepted beat for the bench
   output logic                          got,
   output rx_overrun_pkg::rx_beat_s      got_beat
);
   // Ready decided a cycle ahead, as a real engine would; low in reset so nothing is taken early
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dma_ready <= 1'b0;
      end
      else
      begin
         dma_ready <= ~stall;
      end
   end

   assign desc_head_zero = desc_zero;
   // A beat is taken only where valid meets ready
   assign got            = dma_valid & dma_ready;
   assign got_beat       = dma_beat;
endmodule // dma_sink_model

// File: verification/rx_overrun_statistics_tb.sv
// Self-checking bench for the receive overrun statistics block
`timescale 1ns/100ps
module rx_overrun_statistics_tb;
   logic                     clk, rst_b, rx_valid, stall, desc_zero;
   logic                     dma_valid, dma_ready, desc_head_zero, got;
   rx_overrun_pkg::rx_beat_s rx_beat, dma_beat, got_beat;
   rx_overrun_pkg::rx_qual_s rx_qual;
   logic [31:0]              start_cnt, mid_cnt, desc_cnt;
   int                       err_total, num_checks, seed, occ, exp_s, exp_m, exp_d, zf;
   rx_overrun_pkg::rx_beat_s exp_q[$];

   rx_overrun_statistics #(.CW(32)) dut_u (.clk(clk), .rst_b(rst_b), .rx_valid(rx_valid), .rx_beat(rx_beat),
      .rx_qual(rx_qual), .desc_head_zero(desc_head_zero), .dma_valid(dma_valid), .dma_ready(dma_ready),
      .dma_beat(dma_beat), .rx_start_overrun_count(start_cnt), .rx_middle_overrun_count(mid_cnt),
      .rx_descriptor_overrun_count(desc_cnt));

   dma_sink_model sink_u (.clk(clk), .rst_b(rst_b), .stall(stall), .desc_zero(desc_zero),
      .dma_valid(dma_valid), .dma_ready(dma_ready), .dma_beat(dma_beat),
      .desc_head_zero(desc_head_zero), .got(got), .got_beat(got_beat));

   // 25 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Beats are compared as whole structs so the frame marks are checked too
   task automatic chk_beat(input string what, input rx_overrun_pkg::rx_beat_s exp,
                           input rx_overrun_pkg::rx_beat_s seen);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Every beat the sink takes must be the next one the model let in
   always @(posedge clk)
   begin
      if (got === 1'b1)
      begin
         if (exp_q.size() > 0)
            chk_beat("dma beat", exp_q.pop_front(), got_beat);
         else
            chk("unexpected dma beat", 32'h0, 32'h1);
      end
   end

   // Empty the buffer with ready high, then pick the sink mode
   task automatic drain(input logic s);
      stall <= 1'b0;
      repeat (6) @(posedge clk);
      occ = 0;
      stall <= s;
      @(posedge clk);
   endtask

   // Send one frame; zero head pointer on beats zf..zl; model predicts drops and counts
   task automatic send_frame(input int len, input logic [2:0] q, input int zf, input int zl);
      bit                       drop, s_of, m_of, d_of, dz;
      rx_overrun_pkg::rx_beat_s b;
      drop = 0;
      s_of = 0;
      m_of = 0;
      d_of = 0;
      for (int i = 0; i < len; i++)
      begin
         b.data  = 8'($random(seed));
         b.first = (i == 0);
         b.last  = (i == len - 1);
         dz      = (i >= zf && i <= zl);
         rx_valid  <= 1'b1;
         rx_beat   <= b;
         desc_zero <= dz;
         rx_qual   <= {q, 3'($random(seed))};
         if (!drop)
         begin
            if (dz || (stall && occ >= 2))
            begin
               drop = 1;
               s_of = (i == 0);
               m_of = (i != 0);
               d_of = dz;
            end
            else
            begin
               exp_q.push_back(b);
               if (stall)
                  occ++;
            end
         end
         @(posedge clk);
      end
      rx_valid  <= 1'b0;
      desc_zero <= 1'b0;
      // Errors in the low qual bits play no part in qualifying
      if (q[2] && (q[1] || q[0]))
      begin
         exp_s += s_of;
         exp_m += m_of;
         exp_d += d_of;
      end
      repeat (2) @(posedge clk);
      chk("start count", exp_s, start_cnt);
      chk("middle count", exp_m, mid_cnt);
      chk("descriptor count", exp_d, desc_cnt);
   endtask

   // Main sequence
   initial
   begin
      seed      = 32'h545d6dd0;
      rst_b     = 1'b0;
      rx_valid  = 1'b0;
      rx_beat   = '0;
      rx_qual   = '0;
      stall     = 1'b0;
      desc_zero = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("start after reset", 32'h0, start_cnt);
      drain(1'b0);
      send_frame(1, 3'h6, -1, -1);
      send_frame(1, 3'h6, 0, 0);
      send_frame(1600, 3'h5, 800, 800);
      send_frame(4, 3'h6, 0, 3);
      drain(1'b1);
      send_frame(6, 3'h6, -1, -1);
      send_frame(1, 3'h5, -1, -1);
      send_frame(3, 3'h7, -1, -1);
      send_frame(3, 3'h6, 0, 0);
      drain(1'b0);
      for (int q = 0; q < 8; q++)
         send_frame(3, 3'(q), 1, 1);
      for (int n = 0; n < 40; n++)
      begin
         drain(1'($random(seed)));
         zf = {$random(seed)} % 12;
         send_frame(1 + {$random(seed)} % 8, 3'($random(seed)), zf, zf + {$random(seed)} % 3);
      end
      drain(1'b0);
      chk("beats left over", 32'h0, exp_q.size());
      close_out();
   end

   // Watchdog well beyond the few thousand cycles the sequence needs
   initial
   begin
      #(40 * 20000);
      err_total++;
      close_out();
   end
endmodule // rx_overrun_statistics_tb
